// ### hw/rgbwpw_led_pwm.sv
// Top of the RGBW LED pulse-width modulator with its register file
// Overview of operation
// - Red enable clear forces red low pre-polarity
// - White enable clear forces white low pre-polarity
// - Blue enable clear forces blue low pre-polarity
// - Green enable clear forces green low pre-polarity
// - All colour enables clear resets reference counter
// - Bit 5 selects active audio gate level
// - Bit 4 lets audio gate colour outputs only
// - Polarity bit: 0 inverts, 1 passes, all pins
// - Colour group enable clear holds colour pins high
// - White group enable clear holds white pin high
// - Everything disabled stops the whole PWM clock
// - Divider codes 1:1, 2:1, 4..16:1, else stopped
// - Divider affects colour channels only, not white
// - Turn-off field bits 14-8, off time minus one
// - Turn-on field bits 6-0, zero starts cycle
// - Turn-off 7Fh keeps LED on to cycle end
module rgbwpw_led_pwm (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [15:0] regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdData,
  // Source clock enable and audio gate
  input  wire logic        led_source_clock,
  input  wire logic        audio_gate_in,
  // LED pins
  output logic             red_led_out,
  output logic             green_led_out,
  output logic             blue_led_out,
  output logic             white_led_out
);
  logic [15:0] ctrl_q,  ctrl_d;
  logic [15:0] div_q,   div_d;
  logic [15:0] slope_q, slope_d;
  logic [15:0] white_q, white_d;
  logic [15:0] rd_q,    rd_d;
  logic [15:0] pts_q [3];
  logic [15:0] pts_d [3];
  logic [6:0]  ref_q,   ref_d;
  logic [7:0]  wsub_q,  wsub_d;
  logic [5:0]  wper_q,  wper_d;
  logic [2:0]  col_q,   col_d;
  logic        wht_q,   wht_d;
  logic [3:0]  pin_q,   pin_d;
  logic        run;
  logic        colEn;
  logic        gateOk;
  logic [2:0]  chEn;
  logic [6:0]  onPt  [3];
  logic [6:0]  offPt [3];
  logic [15:0] rdMux;

  rgbwpw_tick_if tick ();

  assign chEn = {ctrl_q[rgbwpw_pkg::BLU_EN_BIT], ctrl_q[rgbwpw_pkg::GRN_EN_BIT],
                 ctrl_q[rgbwpw_pkg::RED_EN_BIT]};
  assign colEn = |chEn;
  assign run = (|ctrl_q[rgbwpw_pkg::BLU_EN_BIT:rgbwpw_pkg::WHT_EN_BIT])
             | ctrl_q[rgbwpw_pkg::RGB_OUT_BIT] | ctrl_q[rgbwpw_pkg::WHT_OUT_BIT];
  assign tick.srcTick = led_source_clock & run;
  assign tick.divSel = div_q[3:0];
  assign tick.run = run & colEn;

  rgbwpw_divider u_div (
    .core_clk (core_clk),
    .reset    (reset),
    .tick     (tick)
  );

  // Register writes
  always_comb begin
    ctrl_d  = ctrl_q;
    div_d   = div_q;
    slope_d = slope_q;
    white_d = white_q;
    for (int i = 0; i < 3; i++) begin
      pts_d[i] = pts_q[i];
    end
    if (regWrite) begin
      case (regAddr)
        rgbwpw_pkg::CTRL_OFS:  ctrl_d  = regWrData & rgbwpw_pkg::CTRL_MASK;
        rgbwpw_pkg::DIV_OFS:   div_d   = regWrData & rgbwpw_pkg::DIV_MASK;
        rgbwpw_pkg::RED_OFS:   pts_d[0] = regWrData & rgbwpw_pkg::POINT_MASK;
        rgbwpw_pkg::GREEN_OFS: pts_d[1] = regWrData & rgbwpw_pkg::POINT_MASK;
        rgbwpw_pkg::BLUE_OFS:  pts_d[2] = regWrData & rgbwpw_pkg::POINT_MASK;
        rgbwpw_pkg::SLOPE_OFS: slope_d = regWrData & rgbwpw_pkg::SLOPE_MASK;
        rgbwpw_pkg::WHITE_OFS: white_d = regWrData & rgbwpw_pkg::WHITE_MASK;
        default: begin
        end
      endcase
    end
  end

  // Register reads
  always_comb begin
    case (regAddr)
      rgbwpw_pkg::CTRL_OFS:   rdMux = ctrl_q;
      rgbwpw_pkg::DIV_OFS:    rdMux = div_q;
      rgbwpw_pkg::RED_OFS:    rdMux = pts_q[0];
      rgbwpw_pkg::GREEN_OFS:  rdMux = pts_q[1];
      rgbwpw_pkg::BLUE_OFS:   rdMux = pts_q[2];
      rgbwpw_pkg::SLOPE_OFS:  rdMux = slope_q;
      rgbwpw_pkg::WHITE_OFS:  rdMux = white_q;
      rgbwpw_pkg::STATUS_OFS: rdMux = {4'h0, pin_q, 1'b0, ref_q};
      default:                rdMux = 16'h0000;
    endcase
    rd_d = regRead ? rdMux : 16'h0000;
  end

  // Colour reference counter and white period counter
  always_comb begin
    ref_d  = ref_q;
    wsub_d = wsub_q;
    wper_d = wper_q;
    if (!colEn) begin
      ref_d = 7'h00;
    end else if (tick.colTick) begin
      ref_d = 7'(ref_q + 7'h01); // wraps 127 to 0
    end
    if (tick.srcTick) begin // white ignores divider
      if (wsub_q == rgbwpw_pkg::WHT_BASE) begin
        wsub_d = 8'h00;
        wper_d = (wper_q >= white_q[5:0]) ? 6'h00 : 6'(wper_q + 6'h01);
      end else begin
        wsub_d = 8'(wsub_q + 8'h01);
      end
    end
  end

  // Colour comparators
  for (genvar c = 0; c < 3; c++) begin : g_col
    assign onPt[c]  = pts_q[c][rgbwpw_pkg::ON_LSB +: 7];
    assign offPt[c] = pts_q[c][rgbwpw_pkg::OFF_LSB +: 7];
    always_comb begin
      // On from turn-on point through off point (off time minus one)
      col_d[c] = (ref_q >= onPt[c]) &&
                 ((offPt[c] == rgbwpw_pkg::FULL_OFF) || (ref_q <= offPt[c]));
    end
  end

  // White modulator: duty field counts periods of 256 source ticks
  always_comb begin
    wht_d = (white_q[13:8] == 6'h3F) || (wper_q <= white_q[13:8]);
  end

  // Gating, group enables and polarity
  always_comb begin
    gateOk = !ctrl_q[rgbwpw_pkg::AUD_EN_BIT] ||
             (audio_gate_in ^ ctrl_q[rgbwpw_pkg::AUD_LVL_BIT]);
    for (int i = 0; i < 3; i++) begin
      // Channel enable and audio gate act before polarity
      pin_d[i] = col_q[i] & chEn[i] & gateOk;
      pin_d[i] = ctrl_q[rgbwpw_pkg::POL_BIT] ? pin_d[i] : !pin_d[i];
      if (!ctrl_q[rgbwpw_pkg::RGB_OUT_BIT]) begin
        pin_d[i] = 1'b1;
      end
    end
    pin_d[3] = wht_q & ctrl_q[rgbwpw_pkg::WHT_EN_BIT];
    pin_d[3] = ctrl_q[rgbwpw_pkg::POL_BIT] ? pin_d[3] : !pin_d[3];
    if (!ctrl_q[rgbwpw_pkg::WHT_OUT_BIT]) begin
      pin_d[3] = 1'b1;
    end
  end

  // Register file storage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q  <= rgbwpw_pkg::REG_RESET;
      div_q   <= rgbwpw_pkg::REG_RESET;
      slope_q <= rgbwpw_pkg::REG_RESET;
      white_q <= rgbwpw_pkg::REG_RESET;
      for (int i = 0; i < 3; i++) begin
        pts_q[i] <= rgbwpw_pkg::REG_RESET;
      end
    end else begin
      ctrl_q  <= ctrl_d;
      div_q   <= div_d;
      slope_q <= slope_d;
      white_q <= white_d;
      pts_q   <= pts_d;
    end
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_q <= 16'h0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  // Reference and white period counters
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ref_q  <= 7'h00;
      wsub_q <= 8'h00;
      wper_q <= 6'h00;
    end else begin
      ref_q  <= ref_d;
      wsub_q <= wsub_d;
      wper_q <= wper_d;
    end
  end

  // Modulator outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      col_q <= 3'h0;
      wht_q <= 1'b0;
    end else begin
      col_q <= col_d;
      wht_q <= wht_d;
    end
  end

  // Pin flops, high while group enables are clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_q <= 4'hF;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign regRdData     = rd_q;
  assign red_led_out   = pin_q[0];
  assign green_led_out = pin_q[1];
  assign blue_led_out  = pin_q[2];
  assign white_led_out = pin_q[3];
endmodule

// ### pkg/rgbwpw_pkg.sv
// Package with register map, field positions and reset values for the LED PWM block
package rgbwpw_pkg;
  localparam logic [15:0] CTRL_OFS     = 16'h3400;
  localparam logic [15:0] DIV_OFS      = 16'h3402;
  localparam logic [15:0] RED_OFS      = 16'h3404;
  localparam logic [15:0] GREEN_OFS    = 16'h3406;
  localparam logic [15:0] BLUE_OFS     = 16'h3408;
  localparam logic [15:0] SLOPE_OFS    = 16'h340A;
  localparam logic [15:0] WHITE_OFS    = 16'h340E;
  localparam logic [15:0] STATUS_OFS   = 16'h3412;
  localparam int          WHT_OUT_BIT  = 0;
  localparam int          RGB_OUT_BIT  = 1;
  localparam int          POL_BIT      = 2;
  localparam int          AUD_EN_BIT   = 4;
  localparam int          AUD_LVL_BIT  = 5;
  localparam int          WHT_EN_BIT   = 8;
  localparam int          RED_EN_BIT   = 9;
  localparam int          GRN_EN_BIT   = 10;
  localparam int          BLU_EN_BIT   = 11;
  localparam int          OFF_LSB      = 8;
  localparam int          ON_LSB       = 0;
  localparam logic [15:0] CTRL_MASK    = 16'h0F37;
  localparam logic [15:0] DIV_MASK     = 16'h000F;
  localparam logic [15:0] POINT_MASK   = 16'h7F7F;
  localparam logic [15:0] SLOPE_MASK   = 16'h7FFF;
  localparam logic [15:0] WHITE_MASK   = 16'h3F3F;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [6:0]  FULL_OFF     = 7'h7F;
  localparam logic [3:0]  DIV_MAX_CODE = 4'h8;
  localparam logic [7:0]  WHT_BASE     = 8'hFF;
endpackage

// ### pkg/rgbwpw_tick_if.sv
// Interface carrying the divided colour tick between prescaler and core
interface rgbwpw_tick_if;
  logic       srcTick;
  logic [3:0] divSel;
  logic       run;
  logic       colTick;
  modport core (output srcTick, output divSel, output run, input colTick);
  modport div  (input srcTick, input divSel, input run, output colTick);
endinterface

// ### hw/rgbwpw_divider.sv
// Colour clock prescaler: 1:1, 2:1, then even ratios to 16:1, stop on reserved codes
module rgbwpw_divider (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   reset,
  // Tick link
  rgbwpw_tick_if.div  tick
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] limit;
  logic       pulse;

  always_comb begin
    limit = (tick.divSel == 4'h0) ? 4'h0 : 4'((tick.divSel << 1) - 4'h1);
    pulse = 1'b0;
    cnt_d = cnt_q;
    if (!tick.run || tick.divSel > rgbwpw_pkg::DIV_MAX_CODE) begin
      cnt_d = 4'h0;
    end else if (tick.srcTick) begin
      if (cnt_q >= limit) begin
        cnt_d = 4'h0;
        pulse = 1'b1;
      end else begin
        cnt_d = 4'(cnt_q + 4'h1);
      end
    end
  end

  assign tick.colTick = pulse;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ### dv/rgbwpw_assertions.sv
// Checker for LED pin gating and status readback
module rgbwpw_assertions (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdData,
  // Pins
  input wire logic        audio_gate_in,
  input wire logic        red_led_out,
  input wire logic        green_led_out,
  input wire logic        blue_led_out,
  input wire logic        white_led_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] c0Q, c1Q, c2Q;
  logic [2:0]  aQ, rgb;
  logic        st, p;
  assign rgb = {red_led_out, green_led_out, blue_led_out};
  assign st  = c1Q == c2Q;
  assign p   = c1Q[2];
  // Shadow of the control register, aged to pin latency
  always_ff @(posedge core_clk) begin
    if (reset) c0Q <= 16'h0000;
    else if (regWrite && regAddr == rgbwpw_pkg::CTRL_OFS) c0Q <= regWrData & rgbwpw_pkg::CTRL_MASK;
    c1Q <= c0Q;
    c2Q <= c1Q;
    aQ  <= {aQ[1:0], audio_gate_in};
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  rgb_hold_a: assert property (st && !c1Q[1] |-> rgb == 3'h7) else $error("rgb not high");
  wht_hold_a: assert property (st && !c1Q[0] |-> white_led_out) else $error("white not high");
  red_force_a: assert property (st && c1Q[1] && !c1Q[9] |-> red_led_out == !p) else $error("red");
  grn_force_a: assert property (st && c1Q[1] && !c1Q[10] |-> green_led_out == !p) else $error("green");
  blu_force_a: assert property (st && c1Q[1] && !c1Q[11] |-> blue_led_out == !p) else $error("blue");
  wht_force_a: assert property (st && c1Q[0] && !c1Q[8] |-> white_led_out == !p) else $error("white");
  aud_gate_a: assert property (st && c1Q[1] && c1Q[4] && aQ == {3{c1Q[5]}} && audio_gate_in == c1Q[5]
    |-> rgb == {3{!p}}) else $error("audio gate");
  ref_zero_a: assert property (st && c1Q[11:9] == 3'h0 && regRead && regAddr == rgbwpw_pkg::STATUS_OFS
    |=> regRdData[6:0] == 7'h00) else $error("ref not zero");
  cover property (st && c1Q[11:8] == 4'hF && c1Q[1:0] == 2'h3);
  cover property (c1Q[4] && audio_gate_in != c1Q[5]);
  cover property (regRead && regAddr == rgbwpw_pkg::STATUS_OFS);
endmodule
bind rgbwpw_led_pwm rgbwpw_assertions rgbwpw_assertions_inst (.core_clk(core_clk), .reset(reset),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .audio_gate_in(audio_gate_in), .red_led_out(red_led_out), .green_led_out(green_led_out),
  .blue_led_out(blue_led_out), .white_led_out(white_led_out));

// ### dv/rgbwpw_source_model.sv
// Source tick generator, fast or slow bursts
module rgbwpw_source_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Burst request
  input  wire logic        load,
  input  wire logic        slow,
  input  wire logic [11:0] count,
  // Tick out
  output logic             srcTick,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] leftQ;
  logic [1:0]  phQ;
  logic        tk;
  assign busy = leftQ != 12'h000;
  assign tk   = busy && !load && (slow ? phQ == 2'h0 : !phQ[0]);
  always_ff @(posedge core_clk) begin
    phQ     <= reset ? 2'h0 : phQ + 2'h1;
    srcTick <= !reset && tk;
    leftQ   <= reset ? 12'h000 : load ? count : leftQ - {11'h000, tk};
  end
endmodule

// ### dv/rgbwpw_led_pwm_test.sv
// Self-checking bench for the RGBW LED PWM block
module rgbwpw_led_pwm_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0, audio = 1'h0;
  logic        load = 1'h0, slow = 1'h0, rdV = 1'h0, pinV = 1'h0, srcTick, busy;
  logic [15:0] regAddr = 16'h0, regWrData = 16'h0, regRdData, d, expQ[$];
  logic [11:0] count = 12'h0;
  wire  [3:0]  pins;
  int          n_fail = 0, n_checks = 0, seed = 32'hfff0e915, i, k;
  logic [15:0] ofs[7] = '{16'h3400, 16'h3402, 16'h3404, 16'h3406, 16'h3408, 16'h340A, 16'h340E};
  logic [15:0] msk[7] = '{16'h0F37, 16'h000F, 16'h7F7F, 16'h7F7F, 16'h7F7F, 16'h7FFF, 16'h3F3F};
  logic [23:0] tbl[12] = '{24'h0F070F, 24'h0F0300, 24'h0D070E, 24'h0B070D, 24'h07070B, 24'h0E0707,
                           24'h0F0107, 24'h0F0208, 24'h0F1708, 24'h0F171F, 24'h0F3718, 24'h0F370F};
  always #5 core_clk = ~core_clk;
  rgbwpw_led_pwm rgbwpw_led_pwm_inst (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .led_source_clock(srcTick), .audio_gate_in(audio), .red_led_out(pins[0]), .green_led_out(pins[1]),
    .blue_led_out(pins[2]), .white_led_out(pins[3]));
  rgbwpw_source_model rgbwpw_source_model_inst (.core_clk(core_clk), .reset(reset), .load(load),
    .slow(slow), .count(count), .srcTick(srcTick), .busy(busy));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got);
    logic [15:0] e;
    e = expQ.pop_front();
    n_checks++;
    if (got !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  // Result watcher: read data one cycle after the strobe, pins on request
  always @(posedge core_clk) begin
    rdV <= regRead;
    if (rdV) check(regRdData);
    if (pinV) check({12'h000, pins});
  end
  task automatic wr(input logic [15:0] a, v);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'h1;
    @(posedge core_clk);
    regWrite <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, e);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'h1;
    expQ.push_back(e);
    @(posedge core_clk);
    regRead <= 1'h0;
  endtask
  task automatic pin(input logic [3:0] e);
    repeat (4) @(posedge core_clk);
    pinV <= 1'h1;
    expQ.push_back({12'h000, e});
    @(posedge core_clk);
    pinV <= 1'h0;
  endtask
  task automatic ticks(input logic [11:0] n);
    int j;
    @(posedge core_clk);
    count <= n;
    load <= 1'h1;
    @(posedge core_clk);
    load <= 1'h0;
    for (j = 0; j < 5000 && (busy || j == 0); j++) @(posedge core_clk);
    if (busy) begin
      n_fail++;
      close_out();
    end
    repeat (4) @(posedge core_clk);
  endtask
  initial begin
    #900000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'h0;
    for (i = 0; i < 7; i++) rd(ofs[i], 16'h0000);
    wr(16'h3410, 16'hFFFF);
    rd(16'h3410, 16'h0000);
    for (i = 0; i < 7; i++) begin
      d = $random(seed);
      wr(ofs[i], d);
      rd(ofs[i], d & msk[i]);
    end
    $display("test registers done");
    for (i = 2; i < 5; i++) wr(ofs[i], 16'h7F00);
    wr(16'h340E, 16'h3F00);
    for (i = 0; i < 12; i++) begin
      audio <= tbl[i][4];
      wr(16'h3400, tbl[i][23:8]);
      pin(tbl[i][3:0]);
    end
    $display("test gating done");
    for (i = 0; i < 16; i++) begin
      slow <= i > 8;
      wr(16'h3400, 16'h0000);
      wr(16'h3402, i[15:0]);
      wr(16'h3400, 16'h0F07);
      rd(16'h3412, 16'h0F00);
      k = i == 0 ? 1 : i * 2;
      ticks(i > 8 ? 12'd40 : k[11:0] * 12'd129);
      rd(16'h3412, i > 8 ? 16'h0F00 : 16'h0F01);
    end
    $display("test divider done");
    wr(16'h3400, 16'h0000);
    wr(16'h3402, 16'h0000);
    wr(16'h3404, 16'h0905);
    wr(16'h3400, 16'h0207);
    for (k = 0; k < 12; k++) begin
      pin({3'h0, k >= 5 && k <= 9});
      ticks(12'h001);
    end
    $display("test window done");
    close_out();
  end
endmodule
